/* File: hw/rpmc_pkg.sv */
// rpmc_pkg: constants and types for the reset and power mode controller
// assumes a 100 MHz aclk and an AXI4-Lite register port with 32-bit data
package rpmc_pkg;

	localparam int          CLK_MHZ           = 100;
	localparam int          PORT_COUNT        = 4;
	// power_up_release_delay in microseconds; rounded down to cycles
	localparam int          POR_DELAY_US      = 300;
	localparam int          POR_DELAY_CYC     = POR_DELAY_US * CLK_MHZ;
	localparam int          WDT_DIV           = 12;

	// register byte addresses (printed offsets are not all multiples of 4)
	localparam logic [11:0] PMC_IDX           = 12'h087;
	localparam logic [11:0] SMC_IDX           = 12'h0FF;
	localparam logic [11:0] RCR_IDX           = 12'h100;
	localparam logic [11:0] STAT_IDX          = 12'h101;
	localparam logic [13:0] PMC_ADDR          = {PMC_IDX, 2'b00};
	localparam logic [13:0] SMC_ADDR          = {SMC_IDX, 2'b00};
	localparam logic [13:0] RCR_ADDR          = {RCR_IDX, 2'b00};
	localparam logic [13:0] STAT_ADDR         = {STAT_IDX, 2'b00};

	localparam int          PMC_IDLE_BIT      = 0;
	localparam int          PMC_STOP_BIT      = 1;
	localparam int          SMC_EN_BIT        = 7;
	localparam int          SMC_STAT_BIT      = 6;
	localparam int          RCR_POR_BIT       = 1;
	localparam int          RCR_SW_BIT        = 4;
	localparam logic [7:0]  PMC_RESET         = 8'h00;
	localparam logic [7:0]  PORT_RESET        = 8'hFF;
	localparam logic [15:0] PC_RESET          = 16'h0000;
	localparam logic [1:0]  AXI_OKAY          = 2'b00;
	localparam logic [1:0]  AXI_SLVERR        = 2'b10;

	typedef enum logic [1:0] {
		RPMC_RUN,
		RPMC_IDLE,
		RPMC_STOP
	} rpmc_mode_e;

	typedef enum {
		RPMC_R_POWER,
		RPMC_R_DELAY,
		RPMC_R_HOLD,
		RPMC_R_DONE
	} rpmc_rst_e;

	// effects of the internal reset on the rest of the core
	typedef struct packed {
		logic        cpu_halt;
		logic        sfr_init;
		logic        irq_tmr_off;
		logic        port_weak_pu;
		logic [15:0] pc_load;
		logic        osc_internal;
		logic        wdt_enable;
	} rpmc_core_s;

	// power mode request outputs
	typedef struct packed {
		logic cpu_clk_gate;
		logic osc_stop;
		logic periph_clk_on;
	} rpmc_pwr_s;

endpackage

/* File: hw/rpmc_rst_seq.sv */
// rpmc_rst_seq: combines reset sources into one synchronous internal reset
// assumes supply and reset inputs are already synchronous to aclk
`timescale 1ns/1ps
`default_nettype none
module rpmc_rst_seq #(
	parameter int POR_CYC = rpmc_pkg::POR_DELAY_CYC
) (
	input  wire logic aclk,
	input  wire logic power_good,
	input  wire logic monitor_trip,
	input  wire logic other_rst,
	output logic      rst_ff,
	output logic      pin_drive_ff,
	output logic      por_exit,
	output logic      other_exit
);
	import rpmc_pkg::*;

	rpmc_rst_e                 state_ff;
	rpmc_rst_e                 nxt_state;
	logic [$clog2(POR_CYC+1)-1:0] cnt_ff;
	logic                      other_seen_ff;

	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			RPMC_R_POWER: if (power_good) nxt_state = RPMC_R_DELAY;
			RPMC_R_DELAY: begin
				// a source still up when the delay ends keeps reset held,
				// so no one-cycle release slips out between the two
				if (!power_good)
					nxt_state = RPMC_R_POWER;
				else if (cnt_ff == '0 && (monitor_trip || other_rst))
					nxt_state = RPMC_R_HOLD;
				else if (cnt_ff == '0)
					nxt_state = RPMC_R_DONE;
			end
			RPMC_R_HOLD: begin
				// no power-up delay after a monitor trip
				if (!monitor_trip && !other_rst)
					nxt_state = RPMC_R_DONE;
			end
			RPMC_R_DONE: begin
				if (!power_good)
					nxt_state = RPMC_R_POWER;
				else if (monitor_trip || other_rst)
					nxt_state = RPMC_R_HOLD;
			end
			default: nxt_state = RPMC_R_POWER;
		endcase
		if (!power_good) nxt_state = RPMC_R_POWER;
	end

	// power_good deasserted acts as the power-on source of the chain
	always_ff @(posedge aclk) begin
		if (!power_good)
			state_ff <= RPMC_R_POWER;
		else
			state_ff <= nxt_state;
	end

	always_ff @(posedge aclk) begin
		if (state_ff != RPMC_R_DELAY)
			cnt_ff <= ($clog2(POR_CYC+1))'(POR_CYC - 1);
		else if (cnt_ff != '0)
			cnt_ff <= cnt_ff - 1'b1;
	end

	// remembers whether the held reset had a power or monitor cause
	always_ff @(posedge aclk) begin
		if (state_ff == RPMC_R_POWER)
			other_seen_ff <= 1'b0;
		else if (state_ff == RPMC_R_DONE && nxt_state == RPMC_R_HOLD)
			other_seen_ff <= !monitor_trip;
		else if (state_ff == RPMC_R_HOLD && monitor_trip)
			other_seen_ff <= 1'b0;
	end

	always_ff @(posedge aclk) begin
		rst_ff       <= (nxt_state != RPMC_R_DONE);
		pin_drive_ff <= (nxt_state == RPMC_R_POWER)
			|| (nxt_state == RPMC_R_DELAY)
			|| (nxt_state == RPMC_R_HOLD && monitor_trip);
	end

	assign por_exit   = (state_ff != RPMC_R_DONE) && (nxt_state == RPMC_R_DONE)
		&& (state_ff != RPMC_R_HOLD || !other_seen_ff);
	assign other_exit = (state_ff == RPMC_R_HOLD) && (nxt_state == RPMC_R_DONE)
		&& other_seen_ff;
endmodule
`default_nettype wire

/* File: hw/rpmc_top.sv */
// rpmc_top: power mode register, reset cause and supply monitor control
// assumes an AXI4-Lite master; supply and reset inputs synchronous to aclk
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - stop request write halts cpu and stops the internal oscillator.
// - idle request write gates cpu clock only; peripheral clocks keep running.
// - stop and idle bits always read back as zero.
// - upper six bits are plain software scratch flags.
// - reset halts cpu, inits registers, fixes ports, disables irqs and timers.
// - reset never clears data memory; only registers (sfr_init) and pc are reinitialised.
// - port latches forced to all ones, open drain, weak pull-ups on.
// - power-on and monitor resets drive the reset pin low while held.
// - on exit pc clears, watchdog on at clock/12; internal oscillator forced only while reset holds.
// - power-up waits for supply good, then the power-up release delay.
// - power-on or monitor reset exit sets the power-on cause flag.
// - every other reset clears the power-on cause flag.
// - monitor enabled after power-on; kept across all other resets.
// - supply below threshold enters reset; supply restored releases it.
// - monitor reset release adds no power-up delay.
// - enabled interrupt ends idle, clears idle bit, resumes execution.
// - stop ends only by reset, then runs the normal sequence.
// - enable bit turns monitor on or off; resets need source selected.
module rpmc_top #(
	parameter int POR_CYC = rpmc_pkg::POR_DELAY_CYC
) (
	input  wire logic          aclk,
	input  wire logic          aresetn,
	input  wire logic [13:0]   s_axi_awaddr,
	input  wire logic          s_axi_awvalid,
	output logic               s_axi_awready,
	input  wire logic [31:0]   s_axi_wdata,
	input  wire logic [3:0]    s_axi_wstrb,
	input  wire logic          s_axi_wvalid,
	output logic               s_axi_wready,
	output logic [1:0]         s_axi_bresp,
	output logic               s_axi_bvalid,
	input  wire logic          s_axi_bready,
	input  wire logic [13:0]   s_axi_araddr,
	input  wire logic          s_axi_arvalid,
	output logic               s_axi_arready,
	output logic [31:0]        s_axi_rdata,
	output logic [1:0]         s_axi_rresp,
	output logic               s_axi_rvalid,
	input  wire logic          s_axi_rready,
	input  wire logic          power_good,
	input  wire logic          supply_above,
	input  wire logic          other_reset_req,
	input  wire logic          instr_done,
	input  wire logic          irq_pending,
	output logic               reset_pin_low,
	output logic               sys_reset,
	output logic               supply_monitor_enable,
	output rpmc_pkg::rpmc_core_s core_ctl,
	output rpmc_pkg::rpmc_pwr_s  pwr_ctl,
	output logic [rpmc_pkg::PORT_COUNT*8-1:0] port_latch,
	output logic [rpmc_pkg::PORT_COUNT-1:0]   port_open_drain,
	output logic               wdt_tick
);
	import rpmc_pkg::*;

	logic [5:0]   flags_ff;
	logic         req_idle_ff;
	logic         req_stop_ff;
	rpmc_mode_e   mode_ff;
	logic         mon_en_ff;
	logic         por_flag_ff;
	logic         mon_src_ff;
	logic         sw_rst_ff;
	logic         rst_int;
	logic         pin_drv;
	logic         por_exit;
	logic         other_exit;
	logic         monitor_trip;
	logic         aw_ok_ff;
	logic         w_ok_ff;
	logic [13:0]  awaddr_ff;
	logic [31:0]  wdata_ff;
	logic [3:0]   wstrb_ff;
	logic         wr_fire;
	logic [3:0]   wdiv_ff;
	logic [31:0]  nxt_rdata;
	logic         nxt_rerr;
	logic         rst_all;
	logic         pmc_wr;
	logic         smc_wr;
	logic         rcr_wr;

	// register index decode; byte address bits 1:0 are don't care
	function automatic logic idx_is(input logic [13:0] addr,
		input logic [11:0] idx);
		return addr[13:2] == idx;
	endfunction

	// only byte lane 0 carries fields; a write without it is dropped
	function automatic logic lane_wr(input logic [13:0] addr,
		input logic [11:0] idx, input logic [3:0] strb);
		return idx_is(addr, idx) && strb[0];
	endfunction

	// bus reset or internal reset clears control state except monitor enable, monitor source and cause flag
	assign rst_all = !aresetn || rst_int;

	// monitor trips only when on and chosen as reset source
	assign monitor_trip = mon_en_ff && mon_src_ff && !supply_above;

	rpmc_rst_seq #(
		.POR_CYC      (POR_CYC)
	) u_seq (
		.aclk         (aclk),
		.power_good   (power_good),
		.monitor_trip (monitor_trip),
		.other_rst    (other_reset_req || sw_rst_ff || !aresetn),
		.rst_ff       (rst_int),
		.pin_drive_ff (pin_drv),
		.por_exit     (por_exit),
		.other_exit   (other_exit)
	);

	// ---- AXI4-Lite write channel
	assign s_axi_awready = !aw_ok_ff && !s_axi_bvalid;
	assign s_axi_wready  = !w_ok_ff && !s_axi_bvalid;
	assign wr_fire       = aw_ok_ff && w_ok_ff && !s_axi_bvalid;
	assign pmc_wr = wr_fire && lane_wr(awaddr_ff, PMC_IDX, wstrb_ff);
	assign smc_wr = wr_fire && lane_wr(awaddr_ff, SMC_IDX, wstrb_ff);
	assign rcr_wr = wr_fire && lane_wr(awaddr_ff, RCR_IDX, wstrb_ff);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_ok_ff  <= 1'b0;
			w_ok_ff   <= 1'b0;
			awaddr_ff <= '0;
			wdata_ff  <= '0;
			wstrb_ff  <= '0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_ok_ff  <= 1'b1;
				awaddr_ff <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_ok_ff  <= 1'b1;
				wdata_ff <= s_axi_wdata;
				wstrb_ff <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_ok_ff <= 1'b0;
				w_ok_ff  <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= AXI_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= (idx_is(awaddr_ff, PMC_IDX)
				|| idx_is(awaddr_ff, SMC_IDX)
				|| idx_is(awaddr_ff, RCR_IDX)) ? AXI_OKAY : AXI_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// ---- power mode register
	always_ff @(posedge aclk) begin
		if (rst_all) begin
			flags_ff    <= PMC_RESET[7:2];
			req_idle_ff <= 1'b0;
			req_stop_ff <= 1'b0;
		end else begin
			if (pmc_wr) begin
				flags_ff    <= wdata_ff[7:2];
				req_idle_ff <= wdata_ff[PMC_IDLE_BIT];
				req_stop_ff <= wdata_ff[PMC_STOP_BIT];
			end else if (instr_done) begin
				req_idle_ff <= 1'b0;
				req_stop_ff <= 1'b0;
			end
		end
	end

	// entry waits for the writing instruction to finish
	always_ff @(posedge aclk) begin
		if (rst_all) begin
			mode_ff <= RPMC_RUN;
		end else begin
			case (mode_ff)
				RPMC_RUN: begin
					if (instr_done && req_stop_ff)
						mode_ff <= RPMC_STOP;
					else if (instr_done && req_idle_ff)
						mode_ff <= RPMC_IDLE;
				end
				RPMC_IDLE: if (irq_pending) mode_ff <= RPMC_RUN;
				RPMC_STOP: mode_ff <= RPMC_STOP;
				default:   mode_ff <= RPMC_RUN;
			endcase
		end
	end

	// ---- supply monitor and reset cause
	// enable survives every reset except loss of power
	always_ff @(posedge aclk) begin
		if (!power_good)
			mon_en_ff <= 1'b1;
		else if (!rst_int && aresetn && smc_wr)
			mon_en_ff <= wdata_ff[SMC_EN_BIT];
	end

	always_ff @(posedge aclk) begin
		if (!power_good) begin
			por_flag_ff <= 1'b1;
			mon_src_ff  <= 1'b0;
		end else if (por_exit) begin
			por_flag_ff <= 1'b1;
		end else if (other_exit) begin
			por_flag_ff <= 1'b0;
			mon_src_ff  <= 1'b0;
		end else if (!rst_int && aresetn && rcr_wr) begin
			// software can select the monitor before or after enabling it
			mon_src_ff  <= wdata_ff[RCR_POR_BIT];
		end
	end

	always_ff @(posedge aclk) begin
		if (rst_all)
			sw_rst_ff <= 1'b0;
		else
			sw_rst_ff <= rcr_wr && wdata_ff[RCR_SW_BIT];
	end

	// ---- AXI4-Lite read channel
	always_comb begin
		nxt_rdata = '0;
		nxt_rerr  = 1'b0;
		case (s_axi_araddr[13:2])
			PMC_IDX:  nxt_rdata[7:0] = {flags_ff, 2'b00};
			SMC_IDX:  begin
				nxt_rdata[SMC_EN_BIT]   = mon_en_ff;
				nxt_rdata[SMC_STAT_BIT] = supply_above;
			end
			RCR_IDX:  nxt_rdata[RCR_POR_BIT] = por_flag_ff;
			STAT_IDX: nxt_rdata[1:0] = mode_ff;
			default:  nxt_rerr = 1'b1;
		endcase
	end

	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= '0;
			s_axi_rresp  <= AXI_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= nxt_rdata;
			s_axi_rresp  <= nxt_rerr ? AXI_SLVERR : AXI_OKAY;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// ---- watchdog clock enable, aclk divided by WDT_DIV
	always_ff @(posedge aclk) begin
		if (rst_all || wdiv_ff == 4'(WDT_DIV - 1))
			wdiv_ff <= '0;
		else
			wdiv_ff <= wdiv_ff + 1'b1;
	end
	assign wdt_tick = (wdiv_ff == 4'(WDT_DIV - 1)) && !rst_int;

	// ---- outputs to the rest of the core
	assign sys_reset             = rst_int;
	assign reset_pin_low         = pin_drv;
	assign supply_monitor_enable = mon_en_ff;

	always_comb begin
		core_ctl.cpu_halt     = rst_int;
		core_ctl.sfr_init     = rst_int;
		core_ctl.irq_tmr_off  = rst_int;
		core_ctl.port_weak_pu = 1'b1;
		core_ctl.pc_load      = PC_RESET;
		core_ctl.osc_internal = rst_int;
		core_ctl.wdt_enable   = !rst_int;
		pwr_ctl.cpu_clk_gate  = mode_ff != RPMC_RUN;
		pwr_ctl.osc_stop      = mode_ff == RPMC_STOP;
		pwr_ctl.periph_clk_on = mode_ff != RPMC_STOP;
	end

	// port latches stay all ones, open drain, while reset holds
	always_comb begin
		port_latch      = rst_int ? {PORT_COUNT{PORT_RESET}} : '1;
		port_open_drain = '1;
	end
endmodule
`default_nettype wire

/* File: test/rpmc_sva.sv */
// rpmc_sva: concurrent checks on the rpmc_top ports
// assumes one aclk domain; bound to rpmc_top from the bench top file
`timescale 1ns/1ps
`default_nettype none
module rpmc_sva import rpmc_pkg::*; #(
	parameter int POR_CYC = POR_DELAY_CYC
) (
	input  wire logic                    aclk,
	input  wire logic                    aresetn,
	input  wire logic                    power_good,
	input  wire logic                    reset_pin_low,
	input  wire logic                    sys_reset,
	input  wire rpmc_core_s              core_ctl,
	input  wire rpmc_pwr_s               pwr_ctl,
	input  wire logic [PORT_COUNT*8-1:0] port_latch,
	input  wire logic [PORT_COUNT-1:0]   port_open_drain,
	input  wire logic                    wdt_tick
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// edges since power_good rose; saturates so long runs never wrap
	logic [15:0] pg_cnt_ff;
	logic [15:0] nxt_pg_cnt;
	assign nxt_pg_cnt = !power_good ? 16'h0000 :
		(pg_cnt_ff == 16'hFFFF) ? pg_cnt_ff : pg_cnt_ff + 16'h0001;
	always_ff @(posedge aclk) begin
		pg_cnt_ff <= nxt_pg_cnt;
	end
	chk_stop_clocks: assert property (
		pwr_ctl.osc_stop |-> pwr_ctl.cpu_clk_gate && !pwr_ctl.periph_clk_on)
		else $error("stop mode left a clock running");
	chk_idle_periph: assert property (
		pwr_ctl.cpu_clk_gate && !pwr_ctl.osc_stop |-> pwr_ctl.periph_clk_on)
		else $error("idle mode stopped peripheral clocks");
	chk_reset_halts: assert property (
		sys_reset |-> core_ctl.cpu_halt && core_ctl.sfr_init
			&& core_ctl.irq_tmr_off)
		else $error("reset without core halt");
	chk_port_state: assert property (
		sys_reset |-> (&port_latch) && (&port_open_drain)
			&& core_ctl.port_weak_pu)
		else $error("ports not at reset state");
	chk_pin_power: assert property (
		!power_good ##1 !power_good |-> reset_pin_low && sys_reset)
		else $error("pin released while supply low");
	chk_exit_dflt: assert property (
		$fell(sys_reset) |-> core_ctl.wdt_enable
			&& core_ctl.pc_load == PC_RESET)
		else $error("wrong defaults at reset exit");
	chk_por_hold: assert property (
		power_good && pg_cnt_ff < POR_CYC - 1 |-> sys_reset)
		else $error("power-up delay cut short");
	chk_wdt_period: assert property (
		wdt_tick ##1 (!sys_reset)[*8] ##1 (!sys_reset)[*3] |-> ##1 wdt_tick)
		else $error("watchdog tick period wrong");
	cov_idle: cover property (pwr_ctl.cpu_clk_gate && !pwr_ctl.osc_stop);
	cov_stop: cover property (pwr_ctl.osc_stop);
	cov_trip: cover property (power_good && reset_pin_low);
	cov_exit: cover property ($fell(sys_reset));
endmodule
`default_nettype wire

/* File: test/rpmc_supply_model.sv */
// rpmc_supply_model: supply rail with power-on and monitor comparators
// assumes the bench sets level_mv; outputs move only on aclk edges
`timescale 1ns/1ps
`default_nettype none
module rpmc_supply_model #(
	parameter int POR_MV = 1000,
	parameter int MON_MV = 1700
) (
	input  wire logic        aclk,
	input  wire logic [11:0] level_mv,
	output var logic         power_good,
	output var logic         supply_above
);
	// two trip points so a brown-out trips the monitor without power-on
	initial begin
		power_good = 1'b0;
		supply_above = 1'b0;
	end
	always @(posedge aclk) begin
		power_good <= int'(level_mv) > POR_MV;
		supply_above <= int'(level_mv) > MON_MV;
	end
endmodule
`default_nettype wire

/* File: test/test_reset_and_power_mode_control.sv */
// test_reset_and_power_mode_control: self-checking bench for rpmc_top
// assumes rpmc_pkg, rpmc_sva and rpmc_supply_model compiled before it
`timescale 1ns/1ps
`default_nettype none
module test_reset_and_power_mode_control;
	import rpmc_pkg::*;
	localparam int POR = 20;
	logic        aclk = 1'b0;
	logic        aresetn;
	logic [13:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, port_latch;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready, power_good, supply_above;
	logic        other_reset_req, instr_done, irq_pending, reset_pin_low;
	logic        sys_reset, supply_monitor_enable, wdt_tick;
	logic [3:0]  port_open_drain;
	logic [3:0]  s_axi_wstrb;
	logic [11:0] level_mv;
	logic [7:0]  v;
	rpmc_core_s  core_ctl;
	rpmc_pwr_s   pwr_ctl;
	int          errors = 0;
	int          n_checks = 0;
	int          c;
	int          exp_en;
	always #5 aclk = ~aclk;
	rpmc_top #(.POR_CYC(POR)) DUT (.aclk, .aresetn, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.power_good, .supply_above, .other_reset_req, .instr_done,
		.irq_pending, .reset_pin_low, .sys_reset, .supply_monitor_enable,
		.core_ctl, .pwr_ctl, .port_latch, .port_open_drain, .wdt_tick);
	rpmc_supply_model u_sup (.aclk, .level_mv, .power_good, .supply_above);
	task automatic close_out;
		$display("checks %0d mismatches %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] s, e);
		n_checks++;
		if (s !== e) begin
			errors++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic tmo(input int k);
		if (k > 200) begin
			errors++;
			close_out();
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge aclk);
	endtask
	task automatic wr(input logic [13:0] a, input logic [7:0] x,
		input logic [1:0] er);
		int k;
		k = 0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h000000, x};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			k++;
			tmo(k);
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		chk("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
	endtask
	task automatic rd(input logic [13:0] a, input logic [31:0] m, e,
		input logic [1:0] er);
		int k;
		k = 0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			k++;
			tmo(k);
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		chk("rdata", s_axi_rdata & m, e);
		chk("rresp", {30'h0, s_axi_rresp}, {30'h0, er});
	endtask
	task automatic waitr(input logic want, output int n);
		n = 0;
		while (sys_reset !== want) begin
			@(posedge aclk);
			n++;
			tmo(n);
		end
	endtask
	// one-cycle strobe on instr_done, or on irq_pending when irq is set
	task automatic pulse(input bit irq);
		if (irq)
			irq_pending <= 1'b1;
		else
			instr_done <= 1'b1;
		step(1);
		{irq_pending, instr_done} <= 2'b00;
		step(2);
	endtask
	initial begin
		aresetn = 1'b0;
		level_mv = 12'h000;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'b000;
		{s_axi_arvalid, s_axi_rready, other_reset_req} = 3'b000;
		{instr_done, irq_pending} = 2'b00;
		s_axi_wstrb = 4'hF;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		void'($urandom(7));
		step(20);
		aresetn <= 1'b1;
		step(3);
		chk("pin_por", reset_pin_low, 1'b1);
		level_mv <= 12'hCE4;
		waitr(1'b0, c);
		chk("por_len", c >= POR && c <= POR + 6, 1'b1);
		chk("pin_rel", reset_pin_low, 1'b0);
		chk("pc", core_ctl.pc_load, PC_RESET);
		chk("ports", port_latch, 32'hFFFFFFFF);
		c = 0;
		repeat (24) begin
			@(posedge aclk);
			c += wdt_tick;
		end
		chk("wdt_ticks", c, 2);
		exp_en = 1;
		rd(PMC_ADDR, '1, 32'h0, AXI_OKAY);
		rd(SMC_ADDR, '1, 32'hC0, AXI_OKAY);
		rd(RCR_ADDR, 32'h2, 32'h2, AXI_OKAY);
		rd(14'h0010, '1, 32'h0, AXI_SLVERR);
		wr(14'h0010, 8'hAA, AXI_SLVERR);
		for (int i = 0; i < 6; i++) begin
			v = 8'($urandom()) & 8'hFD;
			wr(PMC_ADDR, v, AXI_OKAY);
			rd(PMC_ADDR, '1, {24'h0, v & 8'hFC}, AXI_OKAY);
		end
		s_axi_wstrb <= 4'hE;
		wr(PMC_ADDR, ~v & 8'hFC, AXI_OKAY);
		s_axi_wstrb <= 4'hF;
		rd(PMC_ADDR, '1, {24'h0, v & 8'hFC}, AXI_OKAY);
		$display("test registers done");
		wr(PMC_ADDR, 8'h01, AXI_OKAY);
		rd(STAT_ADDR, 32'h3, 32'h0, AXI_OKAY);
		pulse(1'b0);
		rd(STAT_ADDR, 32'h3, 32'h1, AXI_OKAY);
		chk("idle", pwr_ctl, 3'b101);
		pulse(1'b1);
		rd(STAT_ADDR, 32'h3, 32'h0, AXI_OKAY);
		rd(PMC_ADDR, 32'h3, 32'h0, AXI_OKAY);
		$display("test idle done");
		exp_en = 0;
		wr(SMC_ADDR, 8'h00, AXI_OKAY);
		wr(PMC_ADDR, 8'h02, AXI_OKAY);
		pulse(1'b0);
		rd(STAT_ADDR, 32'h3, 32'h2, AXI_OKAY);
		chk("stop", pwr_ctl, 3'b110);
		pulse(1'b1);
		rd(STAT_ADDR, 32'h3, 32'h2, AXI_OKAY);
		other_reset_req <= 1'b1;
		step(4);
		chk("halt", core_ctl.cpu_halt, 1'b1);
		chk("osc", core_ctl.osc_internal, 1'b1);
		chk("pin_other", reset_pin_low, 1'b0);
		other_reset_req <= 1'b0;
		waitr(1'b0, c);
		rd(STAT_ADDR, 32'h3, 32'h0, AXI_OKAY);
		rd(RCR_ADDR, 32'h2, 32'h0, AXI_OKAY);
		rd(SMC_ADDR, 32'h80, exp_en << 7, AXI_OKAY);
		chk("mon_en", supply_monitor_enable, exp_en);
		level_mv <= 12'h5DC;
		step(6);
		chk("mon_off", sys_reset, 1'b0);
		level_mv <= 12'hCE4;
		$display("test stop done");
		exp_en = 1;
		wr(SMC_ADDR, 8'h80, AXI_OKAY);
		step(4);
		wr(RCR_ADDR, 8'h02, AXI_OKAY);
		level_mv <= 12'h5DC;
		step(6);
		chk("trip", {sys_reset, reset_pin_low}, 2'b11);
		level_mv <= 12'hCE4;
		waitr(1'b0, c);
		chk("no_delay", c < POR, 1'b1);
		rd(RCR_ADDR, 32'h2, 32'h2, AXI_OKAY);
		rd(SMC_ADDR, 32'hC0, (exp_en << 7) | 32'h40, AXI_OKAY);
		$display("test monitor done");
		wr(RCR_ADDR, 8'h12, AXI_OKAY);
		waitr(1'b1, c);
		waitr(1'b0, c);
		chk("sw_len", c < POR, 1'b1);
		rd(RCR_ADDR, 32'h2, 32'h0, AXI_OKAY);
		rd(SMC_ADDR, 32'h80, 32'h80, AXI_OKAY);
		chk("mon_en_sw", supply_monitor_enable, 1'b1);
		$display("test software reset done");
		close_out();
	end
endmodule
bind rpmc_top rpmc_sva #(.POR_CYC(POR_CYC)) u_sva (.aclk, .aresetn,
	.power_good, .reset_pin_low, .sys_reset, .core_ctl, .pwr_ctl,
	.port_latch, .port_open_drain, .wdt_tick);
`default_nettype wire
